//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none

// Compare and count
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module testbench;
  import vcs_pkg::*;
  // Short hangovers for sim
  localparam int HS = 20;
  localparam int HL = 40;
  int n_fail = 0;
  int n_tests = 0;
  logic clock = 1'b0, rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest;
  // Detector inputs
  logic voice_active = 1'b0, cpt = 1'b0, dtmf = 1'b0, lflag = 1'b0, aflag = 1'b0;
  logic [1:0] tx_level = 2'h0, tone_field = 2'h0;
  logic lec_exp = 1'b0, pin = 1'b0;
  logic [4:0] tone_code = 5'h00;
  vcs_word_t tone_word, threshold_pad;
  vcs_byte_t acoustic_mode;
  logic tone_word_valid, initial_mode, vox_enable, rx_voice_select, noise_auto;
  logic voice_detected, interrupt_request;
  logic [1:0] vox_threshold_sel, noise_level;
  logic [7:0] line_bits;
  // Lookup cases per tone group
  logic [8:0] sub_a [4] = '{9'h164, 9'h16c, 9'h170, 9'h17f};
  logic [15:0] dat_a [4] = '{16'h6000, 16'h2333, 16'h00a6, 16'h0ccc};
  logic [4:0] code_a [4] = '{5'h00, 5'h08, 5'h08, 5'h17};
  logic [1:0] fld_a [4] = '{2'd0, 2'd1, 2'd2, 2'd0};

  vcs_regs #(.HANG_SHORT_CYCLES(HS), .HANG_LONG_CYCLES(HL), .CNT_W(25)) vcs_regs_inst (
    .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .voice_active(voice_active), .tx_level(tx_level), .cpt_detected(cpt),
    .dtmf_detected(dtmf), .line_answer_tone_flag(lflag), .acoustic_answer_tone_flag(aflag),
    .lec_expansion_mode(lec_exp), .tone_code(tone_code), .tone_field(tone_field),
    .tone_word(tone_word), .tone_word_valid(tone_word_valid), .initial_mode(initial_mode),
    .voice_detect_input_select_pin(pin), .vox_enable(vox_enable),
    .vox_threshold_sel(vox_threshold_sel), .threshold_pad(threshold_pad),
    .rx_voice_select(rx_voice_select), .noise_auto(noise_auto), .noise_level(noise_level),
    .voice_detected(voice_detected), .interrupt_request(interrupt_request),
    .line_canceler_bypass(line_bits[7]), .line_coef_set_one_clear(line_bits[6]),
    .line_coef_set_two_clear(line_bits[5]), .line_howling_detect_enable(line_bits[4]),
    .line_center_clip_enable(line_bits[3]), .line_coef_freeze(line_bits[2]),
    .line_attenuator_disable(line_bits[1]), .line_gain_ctrl_enable(line_bits[0]),
    .acoustic_mode(acoustic_mode));

  // 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end

  // Sole exit
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // One transfer, held until waitrequest low
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge clock);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Timeout ends the run
    if (n >= 20) begin
      `CHK("bus_answer", 1'b0, avs_waitrequest)
      give_verdict();
    end
  endtask : bus_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus_xfer(1'b0, a, 32'h0);
    `CHK(nm, exp, q)
  endtask : rd

  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    // Reset values
    `CHK("bypass_rst", 1'b1, line_bits[7])
    `CHK("irq_rst", 1'b1, interrupt_request)
    rd("vox_rst", 8'h00, 32'h00);
    rd("det_rst", 8'h04, 32'h00);
    rd("line_rst", 8'h08, 32'h80);
    rd("acous_rst", 8'h0c, 32'h80);
    rd("sub_rst", 8'h10, 32'h164);
    rd("mode_rst", 8'h18, 32'h01);
    $display("test reset done");
    // Voice control fields
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {24'h0, 1'b1, 2'(i), 5'b01011});
      repeat (2) @(negedge clock);
      `CHK("thr_sel", 2'(i), vox_threshold_sel)
      `CHK("rx_sel", 1'b1, rx_voice_select)
      `CHK("noise", 3'b111, {noise_auto, noise_level})
      rd("vox_rb", 8'h00, {24'h0, 1'b1, 2'(i), 5'b01011});
    end
    @(posedge clock);
    pin <= 1'b1;
    repeat (10) @(negedge clock);
    `CHK("rx_pin", 1'b0, rx_voice_select)
    @(posedge clock);
    pin <= 1'b0;
    wr(8'h00, 32'h00);
    @(negedge clock);
    `CHK("vox_off", 2'b01, {vox_enable, noise_auto})
    $display("test voice control done");
    // Each line canceler bit alone
    for (int b = 0; b < 8; b++) begin
      wr(8'h08, 32'h1 << b);
      @(negedge clock);
      `CHK("line_bits", 8'(1 << b), line_bits)
      rd("line_rb", 8'h08, 32'h1 << b);
    end
    wr(8'h0c, 32'hff);
    rd("acous_rb", 8'h0c, 32'hbf);
    `CHK("acous_out", 8'hbf, acoustic_mode)
    $display("test canceler modes done");
    // Hangover, short then long
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, k ? 32'h90 : 32'h80);
      voice_active <= 1'b1;
      repeat (4) @(negedge clock);
      `CHK("vd_on", 1'b1, voice_detected)
      @(posedge clock);
      voice_active <= 1'b0;
      repeat (HS * (k + 1) / 2) @(negedge clock);
      `CHK("vd_hold", 1'b1, voice_detected)
      repeat (HS * (k + 1) + 20) @(negedge clock);
      `CHK("vd_end", 1'b0, voice_detected)
    end
    $display("test hangover done");
    // Detection status and event bit
    @(posedge clock);
    voice_active <= 1'b1;
    tx_level <= 2'b10;
    cpt <= 1'b1;
    repeat (4) @(negedge clock);
    `CHK("irq_event", 1'b1, interrupt_request)
    rd("det_cpt", 8'h04, 32'hc8);
    repeat (3) @(negedge clock);
    `CHK("irq_read", 1'b0, interrupt_request)
    rd("det_again", 8'h04, 32'hd8);
    cpt <= 1'b0;
    dtmf <= 1'b1;
    lec_exp <= 1'b1;
    lflag <= 1'b1;
    aflag <= 1'b1;
    repeat (4) @(negedge clock);
    rd("det_dtmf", 8'h04, 32'hc7);
    rd("det_set", 8'h04, 32'hd7);
    lec_exp <= 1'b0;
    repeat (2) @(negedge clock);
    rd("det_noexp", 8'h04, 32'hd4);
    $display("test detection done");
    // Tone table, one sine, two wamble and one single entry
    for (int i = 0; i < 4; i++) begin
      wr(8'h10, {23'h0, sub_a[i]});
      wr(8'h14, {16'h0, dat_a[i]});
      rd("tone_rb", 8'h14, {16'h0, dat_a[i]});
      tone_code <= code_a[i];
      tone_field <= fld_a[i];
      repeat (2) @(negedge clock);
      `CHK("tone_word", dat_a[i], tone_word)
      `CHK("tone_valid", 1'b1, tone_word_valid)
    end
    wr(8'h10, 32'h175);
    wr(8'h14, 32'h47cf);
    @(posedge clock);
    tone_code <= 5'h18;
    repeat (2) @(negedge clock);
    `CHK("pad", 16'h47cf, threshold_pad)
    `CHK("tone_unmapped", 1'b0, tone_word_valid)
    // Outside initial mode writes refused
    wr(8'h18, 32'h0);
    wr(8'h14, 32'h1111);
    rd("tone_kept", 8'h14, 32'h47cf);
    rd("refused", 8'h18, 32'h2);
    `CHK("pad_kept", 16'h47cf, threshold_pad)
    wr(8'h18, 32'h3);
    rd("refused_clr", 8'h18, 32'h1);
    wr(8'h10, 32'h180);
    wr(8'h14, 32'h1111);
    rd("refused_sub", 8'h18, 32'h3);
    wr(8'h1c, 32'hff);
    rd("unmapped", 8'h1c, 32'h0);
    $display("test tone table done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

//--- vcs_map.svh
`ifndef VCS_MAP_SVH
`define VCS_MAP_SVH

// Register word indices; byte address is four times the index
`define VCS_IDX_VOX_CTRL 6'h00
`define VCS_IDX_DETECT 6'h01
`define VCS_IDX_LINE_MODE 6'h02
`define VCS_IDX_ACOUS_MODE 6'h03
`define VCS_IDX_SUBADDR 6'h04
`define VCS_IDX_SUBDATA 6'h05
`define VCS_IDX_MODE 6'h06

// Reset values
`define VCS_RST_VOX_CTRL 8'h00
`define VCS_RST_LINE_MODE 8'h80
`define VCS_RST_ACOUS_MODE 8'h80
`define VCS_RST_SUBADDR 9'h164
`define VCS_RST_PAD 16'h0000

// Writable bit mask of the acoustic register (bit 6 unused)
`define VCS_ACOUS_MASK 8'hbf

// Voice activity control fields
`define VCS_VOX_EN 7
`define VCS_VOX_THR_HI 6
`define VCS_VOX_THR_LO 5
`define VCS_VOX_HANG 4
`define VCS_VOX_RX_SEL 3
`define VCS_VOX_NOISE_SEL 2
`define VCS_VOX_NOISE_HI 1
`define VCS_VOX_NOISE_LO 0

// Detection status fields
`define VCS_DET_EVENT 4

// Line canceler mode fields
`define VCS_LINE_BYPASS 7
`define VCS_LINE_CLR1 6
`define VCS_LINE_CLR2 5
`define VCS_LINE_HOWL 4
`define VCS_LINE_CLIP 3
`define VCS_LINE_FREEZE 2
`define VCS_LINE_ATT_DIS 1
`define VCS_LINE_GAIN 0

// Mode register fields
`define VCS_MODE_INIT 0
`define VCS_MODE_REFUSED 1

// Tone subaddress map
`define VCS_SUB_SINE_BASE 9'h164
`define VCS_SUB_WAMBLE_BASE 9'h168
`define VCS_SUB_SINGLE_BASE 9'h178
`define VCS_SUB_LAST 9'h17f
`define VCS_SUB_PAD 9'h175
`define VCS_TONE_DEPTH 28

// Tone code groups
`define VCS_CODE_SINE 3'b000
`define VCS_CODE_WAMBLE 3'b010
`define VCS_CODE_SINGLE 2'b10

// Hangover times and clock rate
`define VCS_HANG_SHORT_MS 160
`define VCS_HANG_LONG_MS 320
`define VCS_CLK_KHZ 100000

`endif

//--- vcs_pkg.sv
`default_nettype none
package vcs_pkg;
  // Bus transaction phase
  typedef enum logic [1:0] {VCS_IDLE, VCS_BUSY, VCS_DONE} vcs_phase_t;
  // Common data shapes
  typedef logic [15:0] vcs_word_t;
  typedef logic [8:0] vcs_subaddr_t;
  typedef logic [7:0] vcs_byte_t;
endpackage : vcs_pkg
`default_nettype wire

//--- vcs_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "vcs_map.svh"

// Notes on behaviour
// RULE1: Tone table writes accepted only in initial mode
// RULE2: Tone codes map onto fixed indirect subaddresses
// RULE3: Host encodes frequency as hertz times 8.192
// RULE4: Host encodes wamble time as halved ratio minus one
// RULE5: Control bit 7 enables voice activity detection
// RULE6: Bits 6-5 pick the voice threshold level
// RULE7: Threshold pad word lives at subaddress 175h
// RULE8: Bit 4 picks 160 or 320 ms hangover
// RULE9: Bit 3 picks noise or received voice
// RULE10: Bit 2 auto noise, bits 1-0 noise level
// RULE11: Status bit 7 shows voice or silence
// RULE12: Status bits 6-5 show level versus threshold
// RULE13: Event bit clears on detector change, sets on read
// RULE14: Interrupt output is inverse of event bit
// RULE15: Status bits 3 and 2 show tone detections
// RULE16: Status bits 1-0 show answer tone flags
// RULE17: Line bit 7 selects canceler bypass, resets one
// RULE18: Line bits 6 and 5 clear coefficient sets
// RULE19: Line bit 3 enables send-out center clipping
// RULE20: Line bit 2 freezes coefficient adaptation
// RULE21: Line bit 1 disables the 6 dB attenuators
// RULE22: Line bit 0 enables receive-in gain control
// RULE23: Host keeps reserved noise select bit at zero
module vcs_regs #(
  parameter int HANG_SHORT_CYCLES = `VCS_HANG_SHORT_MS * `VCS_CLK_KHZ,
  parameter int HANG_LONG_CYCLES = `VCS_HANG_LONG_MS * `VCS_CLK_KHZ,
  parameter int CNT_W = 25
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Detector results from the speech datapath
  input wire logic voice_active,
  input wire logic [1:0] tx_level,
  input wire logic cpt_detected,
  input wire logic dtmf_detected,
  input wire logic line_answer_tone_flag,
  input wire logic acoustic_answer_tone_flag,
  input wire logic lec_expansion_mode,
  // Tone generator lookup
  input wire logic [4:0] tone_code,
  input wire logic [1:0] tone_field,
  output vcs_pkg::vcs_word_t tone_word,
  output logic tone_word_valid,
  output logic initial_mode,
  // External pin
  input wire logic voice_detect_input_select_pin,
  // Voice activity settings
  output logic vox_enable,
  output logic [1:0] vox_threshold_sel,
  output vcs_pkg::vcs_word_t threshold_pad,
  output logic rx_voice_select,
  output logic noise_auto,
  output logic [1:0] noise_level,
  output logic voice_detected,
  output logic interrupt_request,
  // Line canceler controls
  output logic line_canceler_bypass,
  output logic line_coef_set_one_clear,
  output logic line_coef_set_two_clear,
  output logic line_howling_detect_enable,
  output logic line_center_clip_enable,
  output logic line_coef_freeze,
  output logic line_attenuator_disable,
  output logic line_gain_ctrl_enable,
  // Acoustic canceler settings, passed on whole
  output vcs_pkg::vcs_byte_t acoustic_mode
);
  import vcs_pkg::*;

  // Software registers
  vcs_byte_t voice_activity_control;
  vcs_byte_t line_canceler_mode;
  vcs_byte_t acoustic_canceler_mode;
  vcs_subaddr_t tone_subaddr;
  logic refused;
  // Bus phase and next phase
  vcs_phase_t phase;
  vcs_phase_t next_phase;
  // Detector history for change detection
  logic cpt_q, dtmf_q, line21_q, ac21_q;
  logic det_event;
  // Hangover counter
  logic [CNT_W-1:0] hang_cnt;
  // Pin synchroniser stages and settled value
  logic sel_s1, sel_s2, sel_s3, sel_pin;

  // Bus decode
  wire [5:0] word_idx = avs_address[7:2];
  wire sel_vox = word_idx == `VCS_IDX_VOX_CTRL;
  wire sel_det = word_idx == `VCS_IDX_DETECT;
  wire sel_line = word_idx == `VCS_IDX_LINE_MODE;
  wire sel_acous = word_idx == `VCS_IDX_ACOUS_MODE;
  wire sel_sub = word_idx == `VCS_IDX_SUBADDR;
  wire sel_data = word_idx == `VCS_IDX_SUBDATA;
  wire sel_mode = word_idx == `VCS_IDX_MODE;
  // Completion edge of a held request
  wire done = phase == VCS_DONE;
  wire wr_fire = done && avs_write;
  wire rd_fire = done && avs_read;
  wire lane0 = avs_byteenable[0];
  wire lane01 = avs_byteenable[1] && avs_byteenable[0];

  // Tone table access from the bus
  wire sub_in_range = (tone_subaddr >= `VCS_SUB_SINE_BASE) && (tone_subaddr <= `VCS_SUB_LAST);
  wire [8:0] sub_off = tone_subaddr - `VCS_SUB_SINE_BASE;
  wire data_wr = wr_fire && sel_data && lane01;
  wire data_ok = data_wr && initial_mode && sub_in_range; // [RULE1]
  wire data_refused = data_wr && !data_ok;
  wire [15:0] bus_word;

  // Tone code to subaddress mapping
  wire is_sine = tone_code[4:2] == `VCS_CODE_SINE;
  wire is_wamble = tone_code[4:2] == `VCS_CODE_WAMBLE;
  wire is_single = tone_code[4:3] == `VCS_CODE_SINGLE;
  wire field_zero = tone_field == 2'h0;
  wire code_ok = is_wamble || ((is_sine || is_single) && field_zero);
  wire [8:0] sine_sub = `VCS_SUB_SINE_BASE + {7'h00, tone_code[1:0]};
  wire [8:0] wamble_sub = `VCS_SUB_WAMBLE_BASE + {5'h00, tone_field, tone_code[1:0]};
  wire [8:0] single_sub = `VCS_SUB_SINGLE_BASE + {6'h00, tone_code[2:0]};
  // Wamble frequency two and the two times sit four apart per field
  wire [8:0] gen_sub = is_sine ? sine_sub : (is_wamble ? wamble_sub : single_sub); // [RULE2]
  wire [8:0] gen_off = gen_sub - `VCS_SUB_SINE_BASE;

  // Detection status assembly
  wire vox_en = voice_activity_control[`VCS_VOX_EN];
  wire [1:0] level_shown = vox_en ? tx_level : 2'h0; // [RULE12]
  wire [1:0] answer_shown = lec_expansion_mode ?
                            {line21_q, ac21_q} : 2'h0; // [RULE16]
  wire [7:0] detection_status = {voice_detected, level_shown, det_event,
                                 cpt_q, dtmf_q, answer_shown}; // [RULE11] [RULE15]

  // Any change in tone detector outputs counts as an event
  wire det_change = (cpt_detected ^ cpt_q) | (dtmf_detected ^ dtmf_q) |
                    (line_answer_tone_flag ^ line21_q) |
                    (acoustic_answer_tone_flag ^ ac21_q);
  // Detector change wins over a simultaneous read of the status
  wire next_det_event = det_change ? 1'b0 :
                        ((rd_fire && sel_det) ? 1'b1 : det_event); // [RULE13]

  // Hangover length from the control register
  wire [CNT_W-1:0] hang_len = voice_activity_control[`VCS_VOX_HANG] ?
                              CNT_W'(HANG_LONG_CYCLES) : CNT_W'(HANG_SHORT_CYCLES); // [RULE8]

  // Read data mux, zero for unmapped words
  wire [31:0] rd_mux =
    sel_vox ? {24'h0, voice_activity_control} :
    sel_det ? {24'h0, detection_status} :
    sel_line ? {24'h0, line_canceler_mode} :
    sel_acous ? {24'h0, acoustic_canceler_mode} :
    sel_sub ? {23'h0, tone_subaddr} :
    sel_data ? {16'h0, bus_word} :
    sel_mode ? {30'h0, refused, initial_mode} : 32'h0;

  // Shared tone table, one read port each for the bus and the generator, writes from the bus only
  vcs_tone_mem #(
    .WIDTH(16),
    .DEPTH(`VCS_TONE_DEPTH),
    .AW(5)
  ) u_tone_mem (
    .clock(clock),
    .rst(rst),
    .wr_en(data_ok),
    .wr_addr(sub_off[4:0]),
    .wr_data(avs_writedata[15:0]),
    .rd_a_addr(sub_off[4:0]),
    .rd_a_data(bus_word),
    .rd_b_addr(gen_off[4:0]),
    .rd_b_data(tone_word)
  );

  // Bus phase sequencing, two wait cycles so table reads settle
  always_comb begin
    case (phase)
      VCS_IDLE: next_phase = (avs_read || avs_write) ? VCS_BUSY : VCS_IDLE;
      VCS_BUSY: next_phase = VCS_DONE;
      VCS_DONE: next_phase = VCS_IDLE;
      default: next_phase = VCS_IDLE;
    endcase
  end

  // Bus handshake registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= VCS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      phase <= next_phase;
      avs_waitrequest <= next_phase != VCS_DONE;
      // Capture read data the edge before it is presented
      if (next_phase == VCS_DONE && avs_read) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Voice activity control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      voice_activity_control <= `VCS_RST_VOX_CTRL; // [RULE5]
    end else if (wr_fire && sel_vox && lane0) begin
      voice_activity_control <= avs_writedata[7:0];
    end
  end

  // Line and acoustic canceler mode registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_canceler_mode <= `VCS_RST_LINE_MODE; // [RULE17]
      acoustic_canceler_mode <= `VCS_RST_ACOUS_MODE;
    end else begin
      if (wr_fire && sel_line && lane0) begin
        line_canceler_mode <= avs_writedata[7:0];
      end
      if (wr_fire && sel_acous && lane0) begin
        acoustic_canceler_mode <= avs_writedata[7:0] & `VCS_ACOUS_MASK;
      end
    end
  end

  // Subaddress pointer, mode and refusal flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tone_subaddr <= `VCS_RST_SUBADDR;
      initial_mode <= 1'b1;
      refused <= 1'b0;
    end else begin
      if (wr_fire && sel_sub && lane01) begin
        tone_subaddr <= avs_writedata[8:0];
      end
      if (wr_fire && sel_mode && lane0) begin
        initial_mode <= avs_writedata[`VCS_MODE_INIT];
      end
      // A new refusal wins over a clear in the same cycle
      if (data_refused) begin
        refused <= 1'b1; // [RULE1]
      end else if (wr_fire && sel_mode && lane0 && avs_writedata[`VCS_MODE_REFUSED]) begin
        refused <= 1'b0;
      end
    end
  end

  // Threshold pad shadow, taken from accepted writes at its subaddress
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      threshold_pad <= `VCS_RST_PAD;
    end else if (data_ok && tone_subaddr == `VCS_SUB_PAD) begin
      threshold_pad <= avs_writedata[15:0]; // [RULE7]
    end
  end

  // Generator lookup valid, aligned with the registered table word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tone_word_valid <= 1'b0;
    end else begin
      tone_word_valid <= code_ok; // [RULE2]
    end
  end

  // Detector history and event bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpt_q <= 1'b0;
      dtmf_q <= 1'b0;
      line21_q <= 1'b0;
      ac21_q <= 1'b0;
      det_event <= 1'b0;
      interrupt_request <= 1'b1;
    end else begin
      cpt_q <= cpt_detected; // [RULE15]
      dtmf_q <= dtmf_detected;
      line21_q <= line_answer_tone_flag; // [RULE16]
      ac21_q <= acoustic_answer_tone_flag;
      det_event <= next_det_event;
      interrupt_request <= ~next_det_event; // [RULE14]
    end
  end

  // Hangover timer holds the voice flag after speech stops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hang_cnt <= '0;
      voice_detected <= 1'b0;
    end else begin
      if (!vox_en) begin
        hang_cnt <= '0;
      end else if (voice_active) begin
        hang_cnt <= hang_len; // [RULE8]
      end else if (hang_cnt != '0) begin
        hang_cnt <= hang_cnt - CNT_W'(1);
      end
      voice_detected <= vox_en && (voice_active || hang_cnt != '0); // [RULE5] [RULE11]
    end
  end

  // Three-stage pin synchroniser, a change counts when stages two and three agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      sel_s3 <= 1'b0;
      sel_pin <= 1'b0;
    end else begin
      sel_s1 <= voice_detect_input_select_pin;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      if (sel_s2 == sel_s3) begin
        sel_pin <= sel_s3;
      end
    end
  end

  // Received voice only passes with the select pin held low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_voice_select <= 1'b0;
    end else begin
      rx_voice_select <= voice_activity_control[`VCS_VOX_RX_SEL] && !sel_pin; // [RULE9]
    end
  end

  // Voice activity settings straight from the control register
  assign vox_enable = voice_activity_control[`VCS_VOX_EN]; // [RULE5]
  assign vox_threshold_sel = voice_activity_control[`VCS_VOX_THR_HI:`VCS_VOX_THR_LO]; // [RULE6]
  // Reserved select bit set to one is simply shown as not automatic
  assign noise_auto = !voice_activity_control[`VCS_VOX_NOISE_SEL]; // [RULE10]
  assign noise_level = voice_activity_control[`VCS_VOX_NOISE_HI:`VCS_VOX_NOISE_LO]; // [RULE10]

  // Line canceler controls straight from the mode register
  assign line_canceler_bypass = line_canceler_mode[`VCS_LINE_BYPASS]; // [RULE17]
  assign line_coef_set_one_clear = line_canceler_mode[`VCS_LINE_CLR1]; // [RULE18]
  assign line_coef_set_two_clear = line_canceler_mode[`VCS_LINE_CLR2]; // [RULE18]
  assign line_howling_detect_enable = line_canceler_mode[`VCS_LINE_HOWL];
  assign line_center_clip_enable = line_canceler_mode[`VCS_LINE_CLIP]; // [RULE19]
  assign line_coef_freeze = line_canceler_mode[`VCS_LINE_FREEZE]; // [RULE20]
  assign line_attenuator_disable = line_canceler_mode[`VCS_LINE_ATT_DIS]; // [RULE21]
  assign line_gain_ctrl_enable = line_canceler_mode[`VCS_LINE_GAIN]; // [RULE22]
  assign acoustic_mode = acoustic_canceler_mode;
endmodule : vcs_regs
`default_nettype wire

//--- vcs_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "vcs_map.svh"

module vcs_regs_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Detector inputs and pin
  input wire logic cpt_detected,
  input wire logic dtmf_detected,
  input wire logic line_answer_tone_flag,
  input wire logic acoustic_answer_tone_flag,
  input wire logic voice_detect_input_select_pin,
  // Tone lookup
  input wire logic [4:0] tone_code,
  input wire logic [1:0] tone_field,
  input wire logic tone_word_valid,
  // Voice activity outputs
  input wire logic vox_enable,
  input wire logic [1:0] vox_threshold_sel,
  input wire logic rx_voice_select,
  input wire logic noise_auto,
  input wire logic [1:0] noise_level,
  input wire logic voice_detected,
  input wire logic interrupt_request,
  // Canceler outputs
  input wire logic line_canceler_bypass,
  input wire logic line_coef_set_one_clear,
  input wire logic line_coef_set_two_clear,
  input wire logic line_howling_detect_enable,
  input wire logic line_center_clip_enable,
  input wire logic line_coef_freeze,
  input wire logic line_attenuator_disable,
  input wire logic line_gain_ctrl_enable,
  input wire logic [7:0] acoustic_mode
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Word index and completion strobes
  wire logic [5:0] widx = avs_address[7:2];
  wire logic wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire logic rd_det = avs_read && !avs_waitrequest && (widx == `VCS_IDX_DETECT);
  // Event-raising detectors
  wire logic [3:0] det_bus = {cpt_detected, dtmf_detected, line_answer_tone_flag,
                              acoustic_answer_tone_flag};
  // Unmapped lookups
  wire logic tone_unmapped = (tone_code[4:3] == 2'b11) || (tone_code[4:2] == 3'b001) ||
                             (tone_code[4:2] == 3'b011) ||
                             ((tone_code[4:3] != 2'b01) && (tone_field != 2'b00));
  wire logic [7:0] line_bits = {line_canceler_bypass, line_coef_set_one_clear,
    line_coef_set_two_clear, line_howling_detect_enable, line_center_clip_enable,
    line_coef_freeze, line_attenuator_disable, line_gain_ctrl_enable};

  // Request, two waits, answer
  sequence seq_req_rise;
    $rose(avs_read || avs_write);
  endsequence
  sequence seq_two_wait;
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  wait_two_a: assert property (seq_req_rise |-> seq_two_wait)
    else $error("wait cycles not two");
  wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  wait_req_a: assert property (!avs_waitrequest |-> (avs_read || avs_write))
    else $error("answer without request");
  vox_write_a: assert property (wr_done && widx == `VCS_IDX_VOX_CTRL |=>
    vox_enable == $past(avs_writedata[7]) && vox_threshold_sel == $past(avs_writedata[6:5])
    && noise_auto == !$past(avs_writedata[2]) && noise_level == $past(avs_writedata[1:0]))
    else $error("voice control fields wrong");
  line_write_a: assert property (wr_done && widx == `VCS_IDX_LINE_MODE |=>
    line_bits == $past(avs_writedata[7:0])) else $error("line mode outputs wrong");
  acous_write_a: assert property (wr_done && widx == `VCS_IDX_ACOUS_MODE |=>
    acoustic_mode == ($past(avs_writedata[7:0]) & `VCS_ACOUS_MASK))
    else $error("acoustic mode wrong");
  irq_change_a: assert property ($changed(det_bus) |-> ##[1:2] interrupt_request)
    else $error("event did not raise interrupt");
  irq_read_a: assert property (rd_det && $stable(det_bus) |-> ##[1:2] !interrupt_request)
    else $error("status read kept interrupt");
  pin_block_a: assert property (voice_detect_input_select_pin [*8] |-> !rx_voice_select)
    else $error("voice select with pin high");
  vox_gate_a: assert property (voice_detected |-> (vox_enable || $past(vox_enable)))
    else $error("voice detected with detection off");
  tone_unmapped_a: assert property (tone_unmapped |=> !tone_word_valid)
    else $error("unmapped tone lookup valid");
endmodule : vcs_regs_sva

bind vcs_regs vcs_regs_sva vcs_regs_sva_inst (.*);
`default_nettype wire

//--- vcs_tone_mem.sv
`timescale 1ns/100ps
`default_nettype none
module vcs_tone_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 28,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port for the register bus
  input wire logic [AW-1:0] rd_a_addr,
  output logic [WIDTH-1:0] rd_a_data,
  // Read port for the tone generator
  input wire logic [AW-1:0] rd_b_addr,
  output logic [WIDTH-1:0] rd_b_data
);
  // Table storage, left unreset so it maps onto plain RAM
  logic [WIDTH-1:0] mem [DEPTH];

  // Address guards, out-of-range reads return zero
  wire wr_ok = wr_addr < AW'(DEPTH);
  wire rd_a_ok = rd_a_addr < AW'(DEPTH);
  wire rd_b_ok = rd_b_addr < AW'(DEPTH);

  // Write port
  always_ff @(posedge clock) begin
    if (wr_en && wr_ok) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read ports
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      rd_a_data <= rd_a_ok ? mem[rd_a_addr] : '0;
      rd_b_data <= rd_b_ok ? mem[rd_b_addr] : '0;
    end
  end
endmodule : vcs_tone_mem
`default_nettype wire
